/* core/craf_filter.sv */
// can receive acceptance filter: 14 banks, apb register slave, match index out
// Functional notes
// - fourteen banks, two programmable 32-bit words each
// - width bit picks one 32 or two 16
// - 32-bit word: id, ext id, type, rtr, zero
// - 16-bit half: std id, rtr, type, eid17:15
// - mode bit picks mask or list mode
// - mask compares set bits; list needs exact
// - 32 mask: word one id, word two mask
// - 32 list: both words exact identifiers
// - 16 mask: low half id, high half mask
// - 16 list: four halves, filters n..n+3
// - matching filter number reported, eight bits
// - inactive banks still consume filter numbers
// - 32-bit match beats 16-bit match
// - same width: list beats mask
// - same width and mode: lowest bank wins, then lowest filter in that bank
// - accepted to bank fifo; others silently dropped
// - per-bank fifo select bit
// - only active banks can match
// - mode, width, fifo writes only in config state; bank words also while bank inactive; ctrl and act any time
// - standard and extended identifiers both handled
`timescale 1ns/1ps
module craf_filter (
	input  wire logic                   clock_i,   // 125 mhz clock
	input  wire logic                   rst_n_i,   // async reset, active low
	input  wire craf_pkg::craf_apb_req_t apb_i,    // apb request
	output logic                        pready_o,  // apb ready
	output logic                        pslverr_o, // apb error, unmapped address
	output logic [31:0]                 prdata_o,  // apb read data
	input  wire craf_pkg::craf_frame_t  frame_i,   // decoded frame identifier
	output craf_pkg::craf_result_t      result_o   // accept or drop decision
);
	import craf_pkg::*;

	logic [1:0]  rst_sync_r;
	logic        rst_n;
	craf_state_t s_r;
	craf_state_t s_nxt;

	// per-bank match results
	logic [NUM_BANKS-1:0][3:0] bank_hit;
	logic [NUM_BANKS-1:0][2:0] bank_cnt;
	logic [NUM_BANKS-1:0][1:0] bank_rank;

	// frame words in filter layout
	logic [31:0] frame32;
	logic [15:0] frame16;
	logic [10:0] frame_sid;
	logic [2:0]  frame_eid_hi;

	// register access decode
	logic                 acc_setup;
	logic                 acc_done;
	logic                 addr_bank;
	logic [ADDR_W-1:0]    bank_off;
	logic [3:0]           bank_sel;
	logic                 word_sel;
	logic                 addr_ok;
	logic [31:0]          rd_data;

	// priority scan
	logic [IDX_W-1:0]     base_cnt0;
	logic [IDX_W-1:0]     base_cnt1;
	logic [IDX_W-1:0]     bank_base;
	logic                 found;
	logic [1:0]           best_rank;
	logic                 best_fifo;
	logic [IDX_W-1:0]     best_idx;

	// reset release through two flops
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// frame identifier mapped to both layouts
	always_comb begin
		frame_sid    = frame_i.ext ? frame_i.id[28:18] : frame_i.id[10:0];
		frame_eid_hi = frame_i.ext ? frame_i.id[17:15] : 3'h0;
		frame32      = frame_i.ext ? {frame_i.id[28:0], 1'b1, frame_i.rtr, 1'b0}
		                           : {frame_i.id[10:0], 18'h0, 1'b0, frame_i.rtr, 1'b0};
		frame16      = {frame_sid, frame_i.rtr, frame_i.ext, frame_eid_hi};
	end

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic [31:0] w1;
			logic [31:0] w2;
			logic [3:0]  raw;
			assign w1 = s_r.word_one[b];
			assign w2 = s_r.word_two[b];
			always_comb begin
				raw = 4'h0;
				unique case ({s_r.width[b], s_r.mode[b]})
					2'b10: begin
						raw[0] = ((frame32 ^ w1) & w2) == 32'h0;
					end
					2'b11: begin
						raw[0] = frame32 == w1;
						raw[1] = frame32 == w2;
					end
					2'b00: begin
						raw[0] = ((frame16 ^ w1[HALF_W-1:0]) & w1[31:HALF_W]) == 16'h0;
						raw[1] = ((frame16 ^ w2[HALF_W-1:0]) & w2[31:HALF_W]) == 16'h0;
					end
					2'b01: begin
						raw[0] = frame16 == w1[HALF_W-1:0];
						raw[1] = frame16 == w1[31:HALF_W];
						raw[2] = frame16 == w2[HALF_W-1:0];
						raw[3] = frame16 == w2[31:HALF_W];
					end
				endcase
			end
			assign bank_hit[b]  = s_r.act[b] ? raw : 4'h0;
			assign bank_cnt[b]  = s_r.width[b] ? (s_r.mode[b] ? CNT_32_LIST : CNT_32_MASK)
			                                   : (s_r.mode[b] ? CNT_16_LIST : CNT_16_MASK);
			assign bank_rank[b] = s_r.width[b] ? (s_r.mode[b] ? RANK_32_LIST : RANK_32_MASK)
			                                   : (s_r.mode[b] ? RANK_16_LIST : RANK_16_MASK);
		end
	endgenerate

	// pick the winning filter and its number
	always_comb begin
		base_cnt0 = '0;
		base_cnt1 = '0;
		bank_base = '0;
		found     = 1'b0;
		best_rank = RANK_16_MASK;
		best_fifo = 1'b0;
		best_idx  = '0;
		for (int i = 0; i < NUM_BANKS; i++) begin
			bank_base = s_r.fifo[i] ? base_cnt1 : base_cnt0;
			for (int k = 0; k < 4; k++) begin
				// strict compare keeps the filter met first in bank order on ties
				if (bank_hit[i][k] && (!found || bank_rank[i] > best_rank)) begin
					found     = 1'b1;
					best_rank = bank_rank[i];
					best_fifo = s_r.fifo[i];
					best_idx  = bank_base + IDX_W'(k);
				end
			end
			// counted whether or not the bank is active
			if (s_r.fifo[i]) begin
				base_cnt1 = base_cnt1 + IDX_W'(bank_cnt[i]);
			end else begin
				base_cnt0 = base_cnt0 + IDX_W'(bank_cnt[i]);
			end
		end
	end

	// apb address decode and read mux
	always_comb begin
		acc_setup = apb_i.psel && !apb_i.penable;
		acc_done  = apb_i.psel && apb_i.penable && s_r.rsp.pready;
		addr_bank = (apb_i.paddr >= OFF_BANK_BASE) && (apb_i.paddr <= OFF_BANK_LAST)
		            && (apb_i.paddr[1:0] == 2'h0);
		bank_off  = apb_i.paddr - OFF_BANK_BASE;
		bank_sel  = bank_off[BANK_SHIFT+3:BANK_SHIFT];
		word_sel  = apb_i.paddr[WORD_SEL_BIT];
		rd_data   = 32'h0;
		addr_ok   = 1'b1;
		if (addr_bank) begin
			rd_data = word_sel ? s_r.word_two[bank_sel] : s_r.word_one[bank_sel];
		end else begin
			unique case (apb_i.paddr)
				OFF_CTRL:  rd_data[CFG_STATE_BIT] = s_r.cfg_state;
				OFF_MODE:  rd_data[NUM_BANKS-1:0] = s_r.mode;
				OFF_WIDTH: rd_data[NUM_BANKS-1:0] = s_r.width;
				OFF_FIFO:  rd_data[NUM_BANKS-1:0] = s_r.fifo;
				OFF_ACT:   rd_data[NUM_BANKS-1:0] = s_r.act;
				default:   addr_ok = 1'b0;
			endcase
		end
	end

	// next state: register writes, apb answer, filter result
	always_comb begin
		s_nxt     = s_r;
		s_nxt.res = '0;
		if (acc_setup) begin
			s_nxt.rsp.pready  = 1'b1;
			s_nxt.rsp.pslverr = !addr_ok;
			s_nxt.rsp.prdata  = rd_data;
		end else if (acc_done) begin
			s_nxt.rsp = '0;
		end
		if (acc_done && apb_i.pwrite && addr_ok) begin
			if (addr_bank) begin
				// words locked while their bank is active and cfg_state is clear
				if (s_r.cfg_state || !s_r.act[bank_sel]) begin
					if (word_sel) begin
						s_nxt.word_two[bank_sel] = apb_i.pwdata;
					end else begin
						s_nxt.word_one[bank_sel] = apb_i.pwdata;
					end
				end
			end else begin
				unique case (apb_i.paddr)
					OFF_CTRL: s_nxt.cfg_state = apb_i.pwdata[CFG_STATE_BIT];
					OFF_MODE: begin
						if (s_r.cfg_state) begin
							s_nxt.mode = apb_i.pwdata[NUM_BANKS-1:0];
						end
					end
					OFF_WIDTH: begin
						if (s_r.cfg_state) begin
							s_nxt.width = apb_i.pwdata[NUM_BANKS-1:0];
						end
					end
					OFF_FIFO: begin
						if (s_r.cfg_state) begin
							s_nxt.fifo = apb_i.pwdata[NUM_BANKS-1:0];
						end
					end
					OFF_ACT:  s_nxt.act = apb_i.pwdata[NUM_BANKS-1:0];
					default:  s_nxt.act = s_r.act;
				endcase
			end
		end
		if (frame_i.valid) begin
			s_nxt.res.accept      = found;
			s_nxt.res.drop        = !found;
			s_nxt.res.fifo        = found && best_fifo;
			s_nxt.res.match_index = found ? best_idx : '0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s_r           <= '0;
			s_r.cfg_state <= CFG_STATE_RST;
			s_r.mode      <= BANK_CFG_RST;
			s_r.width     <= BANK_CFG_RST;
			s_r.fifo      <= BANK_CFG_RST;
			s_r.act       <= BANK_CFG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready_o  = s_r.rsp.pready;
	assign pslverr_o = s_r.rsp.pslverr;
	assign prdata_o  = s_r.rsp.prdata;
	assign result_o  = s_r.res;

endmodule

/* include/craf_pkg.sv */
// constants, carrier structs and state type for the can receive acceptance filter
package craf_pkg;

	localparam int          NUM_BANKS     = 14;
	localparam int          ADDR_W        = 12;
	localparam int          IDX_W         = 8;

	// register byte offsets
	localparam logic [11:0] OFF_CTRL      = 12'h200;
	localparam logic [11:0] OFF_MODE      = 12'h204;
	localparam logic [11:0] OFF_WIDTH     = 12'h20c;
	localparam logic [11:0] OFF_FIFO      = 12'h214;
	localparam logic [11:0] OFF_ACT       = 12'h21c;
	localparam logic [11:0] OFF_BANK_BASE = 12'h240;
	localparam logic [11:0] OFF_BANK_LAST = 12'h2ac;
	localparam int          BANK_SHIFT    = 3;
	localparam int          WORD_SEL_BIT  = 2;

	// field positions and reset values
	localparam int          CFG_STATE_BIT = 0;
	localparam logic        CFG_STATE_RST = 1'b1;
	localparam logic [13:0] BANK_CFG_RST  = 14'h0000;
	localparam logic [31:0] WORD_RST      = 32'h0000_0000;
	localparam int          HALF_W        = 16;

	// filter numbers consumed per bank
	localparam logic [2:0]  CNT_32_MASK   = 3'h1;
	localparam logic [2:0]  CNT_32_LIST   = 3'h2;
	localparam logic [2:0]  CNT_16_MASK   = 3'h2;
	localparam logic [2:0]  CNT_16_LIST   = 3'h4;

	// ranking of filter kinds, higher wins
	localparam logic [1:0]  RANK_32_LIST  = 2'h3;
	localparam logic [1:0]  RANK_32_MASK  = 2'h2;
	localparam logic [1:0]  RANK_16_LIST  = 2'h1;
	localparam logic [1:0]  RANK_16_MASK  = 2'h0;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} craf_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} craf_apb_rsp_t;

	typedef struct packed {
		logic        valid;
		logic        ext;   // identifier_type: 1 = extended
		logic        rtr;
		logic [28:0] id;    // standard id sits in id[10:0]
	} craf_frame_t;

	typedef struct packed {
		logic             accept;
		logic             drop;
		logic             fifo;
		logic [IDX_W-1:0] match_index;
	} craf_result_t;

	typedef struct packed {
		logic                            cfg_state;
		logic [NUM_BANKS-1:0]            mode;
		logic [NUM_BANKS-1:0]            width;
		logic [NUM_BANKS-1:0]            fifo;
		logic [NUM_BANKS-1:0]            act;
		logic [NUM_BANKS-1:0][31:0]      word_one;
		logic [NUM_BANKS-1:0][31:0]      word_two;
		craf_apb_rsp_t                   rsp;
		craf_result_t                    res;
	} craf_state_t;

endpackage

/* verification/craf_filter_checker.sv */
// port assertions for the can acceptance filter
`timescale 1ns/1ps
module craf_filter_checker (
	input wire logic                    clock_i,   // clock
	input wire logic                    rst_n_i,   // async reset
	input wire craf_pkg::craf_apb_req_t apb_i,     // apb request
	input wire logic                    pready_o,  // apb ready
	input wire logic                    pslverr_o, // apb error
	input wire logic [31:0]             prdata_o,  // read data
	input wire craf_pkg::craf_frame_t   frame_i,   // frame in
	input wire craf_pkg::craf_result_t  result_o   // decision
);
	import craf_pkg::*;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic setup = apb_i.psel && !apb_i.penable;
	property p_ready; setup |=> pready_o ##1 !pready_o; endproperty
	a_ready: assert property (p_ready) else $error("ready not one cycle");
	property p_err; pslverr_o |-> pready_o; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rd0; !pready_o |-> prdata_o == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside access");
	property p_hole; setup && apb_i.paddr == 12'h208 |=> pslverr_o; endproperty
	a_hole: assert property (p_hole) else $error("hole not refused");
	property p_end; setup && apb_i.paddr > 12'h2ac |=> pslverr_o && prdata_o == 32'h0; endproperty
	a_end: assert property (p_end) else $error("address past banks not refused");
	property p_dec; frame_i.valid |=> result_o.accept != result_o.drop; endproperty
	a_dec: assert property (p_dec) else $error("no single decision");
	property p_cause; result_o.accept || result_o.drop |-> $past(frame_i.valid); endproperty
	a_cause: assert property (p_cause) else $error("decision without frame");
	property p_didx; result_o.drop |-> result_o.match_index == 8'h0 && !result_o.accept; endproperty
	a_didx: assert property (p_didx) else $error("drop with index");
endmodule
bind craf_filter craf_filter_checker u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .apb_i(apb_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .frame_i(frame_i),
	.result_o(result_o));

/* verification/craf_frame_src.sv */
// receive path model handing decoded identifiers to the filter
`timescale 1ns/1ps
module craf_frame_src (
	input  wire logic             clock_i, // clock
	output craf_pkg::craf_frame_t frame_o  // frame identifier out
);
	import craf_pkg::*;
	initial frame_o = '0;
	task automatic send(input logic e, input logic r, input logic [28:0] id);
		@(posedge clock_i);
		frame_o <= '{1'b1, e, r, id};
		@(posedge clock_i);
		frame_o <= '{1'b0, ~e, ~r, ~id};
	endtask
endmodule

/* verification/craf_filter_tb_top.sv */
// self-checking bench for the can acceptance filter
`timescale 1ns/1ps
module craf_filter_tb_top;
	import craf_pkg::*;
	logic          clock_i;
	logic          rst_n_i;
	craf_apb_req_t apb;
	logic          pready;
	logic          pslverr;
	logic [31:0]   prdata;
	logic [31:0]   rd;
	logic          er;
	craf_frame_t   frame;
	craf_result_t  res;
	int            err_count = 0;
	int            checks = 0;
	int            cyc = 0;
	craf_filter dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .apb_i(apb), .pready_o(pready),
		.pslverr_o(pslverr), .prdata_o(prdata), .frame_i(frame), .result_o(res));
	craf_frame_src src (.clock_i(clock_i), .frame_o(frame));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock_i);
		apb.penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask
	task automatic fr(input logic e, input logic r, input logic [28:0] id, input logic [10:0] x);
		src.send(e, r, id);
		#1;
		chk("decision", {21'h0, res.drop, res.accept, res.fifo & res.accept,
			res.match_index}, {21'h0, x});
	endtask
	task automatic t_regs();
		bus(1'b0, OFF_CTRL, '0);
		chk("ctrl", rd, 32'h1);
		bus(1'b0, OFF_ACT, '0);
		chk("act", rd, 32'h0);
		bus(1'b0, 12'h208, '0);
		chk("hole", {31'h0, er}, 32'h1);
		bus(1'b0, 12'h2b0, '0);
		chk("past end", {31'h0, er}, 32'h1);
		bus(1'b0, 12'h241, '0);
		chk("unaligned", {31'h0, er}, 32'h1);
		bus(1'b1, OFF_BANK_LAST, 32'h5a5a_0001);
		bus(1'b0, OFF_BANK_LAST, '0);
		chk("last word", rd, 32'h5a5a_0001);
		$display("test regs done");
	endtask
	task automatic t_cfg();
		logic [43:0] t [16] = '{{OFF_CTRL, 32'h1}, {OFF_MODE, 32'h16}, {OFF_WIDTH, 32'h5},
			{OFF_FIFO, 32'h4}, {OFF_ACT, 32'h1d}, {12'h240, 32'h2460_0000},
			{12'h244, 32'hffe0_0000}, {12'h248, 32'h8ac0_8ac0}, {12'h24c, 32'h8ac0_8ac0},
			{12'h250, 32'hd5e6_f784}, {12'h254, 32'h2460_0000}, {12'h258, 32'hffe8_8ac0},
			{12'h25c, 32'h0}, {12'h260, 32'hf120_8ac0}, {12'h264, 32'h0}, {OFF_CTRL, 32'h0}};
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, t[i][43:32], t[i][31:0]);
		end
		$display("test config done");
	endtask
	task automatic t_match();
		fr(1'b0, 1'b0, 29'h123, {3'b011, 8'h01});
		fr(1'b1, 1'b0, 29'h1abcdef0, {3'b011, 8'h00});
		fr(1'b1, 1'b0, 29'h048c0005, {3'b010, 8'h00});
		fr(1'b0, 1'b0, 29'h456, {3'b010, 8'h07});
		fr(1'b0, 1'b0, 29'h789, {3'b010, 8'h08});
		fr(1'b0, 1'b1, 29'h456, {3'b010, 8'h05});
		$display("test match done");
	endtask
	task automatic t_prot();
		bus(1'b1, OFF_MODE, '0);
		chk("protect err", {31'h0, er}, 32'h0);
		bus(1'b0, OFF_MODE, '0);
		chk("mode", rd, 32'h16);
		bus(1'b0, OFF_WIDTH, '0);
		chk("width", rd, 32'h5);
		bus(1'b0, OFF_FIFO, '0);
		chk("fifo", rd, 32'h4);
		bus(1'b1, 12'h250, '0);
		bus(1'b0, 12'h250, '0);
		chk("active word", rd, 32'hd5e6_f784);
		bus(1'b1, OFF_ACT, 32'h15);
		bus(1'b1, 12'h258, 32'h1234);
		bus(1'b0, 12'h258, '0);
		chk("idle word", rd, 32'h1234);
		fr(1'b0, 1'b0, 29'h124, {3'b100, 8'h00});
		$display("test protect done");
	endtask
	initial begin
		rst_n_i = 1'b0;
		apb = '0;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_regs();
		t_cfg();
		t_match();
		t_prot();
		complete_run();
	end
endmodule
